/* File: core/atr_map.vh */
`ifndef ATR_MAP_VH
`define ATR_MAP_VH

// wishbone register byte offsets
`define ATR_ADR_ADV_KIND     8'h00
`define ATR_ADR_ADV_SRC      8'h04
`define ATR_ADR_ADV_POL      8'h08
`define ATR_ADR_ARM_KIND     8'h0c
`define ATR_ADR_ARM_SRC      8'h10
`define ATR_ADR_ARM_POL      8'h14
`define ATR_ADR_EXPORT       8'h18
`define ATR_ADR_REC_HOLDOFF  8'h1c
`define ATR_ADR_START_HOLDOFF 8'h20
`define ATR_ADR_SW_TRIG      8'h24
`define ATR_ADR_STATUS       8'h28

// trigger kind codes
`define ATR_KIND_NONE        10'h258
`define ATR_KIND_DIG_EDGE    10'h259
`define ATR_KIND_SOFTWARE    10'h25c

// edge polarity codes
`define ATR_POL_RISING       10'h384
`define ATR_POL_FALLING      10'h385

// terminal codes: none, front 0/1, backplane 0..7, star
`define ATR_TERM_NONE        4'h0
`define ATR_TERM_LAST        4'hb
`define ATR_NUM_LINES        11

// export register field positions
`define ATR_EXP_REF_LSB      0
`define ATR_EXP_ADV_LSB      4
`define ATR_EXP_RST_LSB      8
`define ATR_EXP_RADV_LSB     12

// software trigger and status bit positions
`define ATR_SW_ADV_BIT       0
`define ATR_SW_ARM_BIT       1
`define ATR_ST_START_BUSY    0
`define ATR_ST_REC_BUSY      1
`define ATR_ST_STARTED       2

// clock period in ns (200 MHz); holdoff registers hold ns
`define ATR_CLK_PERIOD_NS    33'h5

`endif

/* File: core/atr_holdoff.v */
`timescale 1ns/1ps
`default_nettype none
`include "atr_map.vh"

module atr_holdoff (
   input  wire        clock_i,   // system clock
   input  wire        nrst_i,    // async reset, active low
   input  wire        ce_i,      // clock enable
   input  wire        start_i,   // restart the holdoff window
   input  wire [31:0] limit_i,   // holdoff length in ns
   output wire        busy_o     // window still running
);

   reg  [32:0] elapsed_r;
   reg  [32:0] limit_r;
   reg         busy_r;
   wire [32:0] elapsed_nxt = elapsed_r + `ATR_CLK_PERIOD_NS;

   assign busy_o = busy_r;

   // elapsed time advances one clock period per cycle; zero length never busies
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         elapsed_r <= 33'h0;
         limit_r   <= 33'h0;
         busy_r    <= 1'b0;
      end else if (ce_i) begin
         if (start_i) begin
            elapsed_r <= 33'h0;
            limit_r   <= {1'b0, limit_i};
            busy_r    <= (limit_i != 32'h0);
         end else if (busy_r) begin
            elapsed_r <= elapsed_nxt;
            if (elapsed_nxt >= limit_r) begin
               busy_r <= 1'b0;
            end
         end
      end
   end

endmodule
`default_nettype wire

/* File: core/atr_edge_trig.v */
`timescale 1ns/1ps
`default_nettype none
`include "atr_map.vh"

module atr_edge_trig (
   input  wire                      clock_i,  // system clock
   input  wire                      nrst_i,   // async reset, active low
   input  wire                      ce_i,     // clock enable
   input  wire [`ATR_NUM_LINES-1:0] lines_i,  // synchronised terminal levels
   input  wire [9:0]                kind_i,   // trigger kind code
   input  wire [3:0]                src_i,    // source terminal code
   input  wire [9:0]                pol_i,    // edge polarity code
   input  wire                      sw_i,     // software trigger pulse
   output wire                      trig_o    // one-cycle trigger pulse
);

   reg  level_r;
   reg  trig_r;
   wire src_ok  = (src_i != `ATR_TERM_NONE) && (src_i <= `ATR_TERM_LAST);
   wire level   = src_ok ? lines_i[src_i - 4'h1] : 1'b0;
   wire rise    = level & ~level_r;
   wire fall    = ~level & level_r;
   wire edge_ok = ((pol_i == `ATR_POL_RISING) & rise) | ((pol_i == `ATR_POL_FALLING) & fall);
   wire fire    = ((kind_i == `ATR_KIND_DIG_EDGE) & edge_ok) | ((kind_i == `ATR_KIND_SOFTWARE) & sw_i);

   assign trig_o = trig_r;

   // none or unknown kind never fires
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         level_r <= 1'b0;
         trig_r  <= 1'b0;
      end else if (ce_i) begin
         level_r <= level;
         trig_r  <= fire;
      end
   end

endmodule
`default_nettype wire

/* File: core/atr_router.v */
// Functional notes
// RULE1: reference trigger exported to one selectable terminal
// RULE2: record holdoff blocks next reference trigger
// RULE3: start holdoff blocks reference after start
// RULE4: advance kind none never asserts advance
// RULE5: digital edge advance fires on source edge
// RULE6: software advance fires on software command
// RULE7: advance edge source selectable among eleven inputs
// RULE8: advance trigger exported to selectable terminal
// RULE9: arm reference kind none never asserts
// RULE10: digital edge arm fires on source edge
// RULE11: software arm fires on software command
// RULE12: arm edge source selectable among eleven inputs
// RULE13: ready for start exported to terminal
// RULE14: ready for advance exported to terminal
// RULE15: rising or falling edge per polarity code
// RULE16: exports pulse; unselected terminals stay undriven
// RULE17: holdoff counts clock time; zero means immediate
`timescale 1ns/1ps
`default_nettype none
`include "atr_map.vh"

module atr_router (
   input  wire                      clock_i,       // 200 MHz system clock
   input  wire                      nrst_i,        // async reset, active low
   input  wire                      ce_i,          // clock enable, freezes all state
   input  wire                      wb_cyc_i,      // wishbone cycle
   input  wire                      wb_stb_i,      // wishbone strobe
   input  wire                      wb_we_i,       // wishbone write enable
   input  wire [7:0]                wb_adr_i,      // wishbone byte address
   input  wire [3:0]                wb_sel_i,      // wishbone byte enables
   input  wire [31:0]               wb_dat_i,      // wishbone write data
   output wire [31:0]               wb_dat_o,      // wishbone read data
   output wire                      wb_ack_o,      // wishbone acknowledge
   input  wire                      start_trig_i,  // start trigger accepted pulse
   input  wire                      ref_trig_i,    // reference trigger candidate pulse
   input  wire                      ready_start_i, // ready for start event pulse
   input  wire                      ready_adv_i,   // ready for advance event pulse
   output wire                      ref_trig_o,    // reference trigger recognised pulse
   output wire                      adv_trig_o,    // advance trigger pulse
   output wire                      arm_ref_o,     // arm reference trigger pulse
   input  wire [`ATR_NUM_LINES-1:0] term_i,        // terminal pin levels
   output wire [`ATR_NUM_LINES-1:0] term_o,        // terminal pin drive values
   output wire [`ATR_NUM_LINES-1:0] term_oe_o      // terminal pin output enables
);

   // configuration registers
   reg  [9:0]  advance_trig_kind_r;
   reg  [3:0]  advance_edge_source_r;
   reg  [9:0]  advance_edge_pol_r;
   reg  [9:0]  arm_ref_trig_kind_r;
   reg  [3:0]  arm_ref_edge_source_r;
   reg  [9:0]  arm_ref_edge_pol_r;
   reg  [15:0] export_r;
   reg  [31:0] record_to_record_holdoff_r;
   reg  [31:0] start_to_record_holdoff_r;
   reg         sw_adv_r;
   reg         sw_arm_r;
   reg         started_r;
   reg         ack_r;
   reg  [31:0] rdata_r;
   reg  [31:0] rdata_nxt;

   // pin synchronisers
   reg  [`ATR_NUM_LINES-1:0] sync1_r;
   reg  [`ATR_NUM_LINES-1:0] sync2_r;

   // export stage
   reg                       ref_out_r;
   reg  [`ATR_NUM_LINES-1:0] term_r;
   reg  [`ATR_NUM_LINES-1:0] term_oe_r;

   wire [3:0] ref_trig_export_select     = export_r[`ATR_EXP_REF_LSB +: 4];
   wire [3:0] advance_export_select      = export_r[`ATR_EXP_ADV_LSB +: 4];
   wire [3:0] ready_start_export_select  = export_r[`ATR_EXP_RST_LSB +: 4];
   wire [3:0] ready_advance_export_select = export_r[`ATR_EXP_RADV_LSB +: 4];

   wire       req    = wb_cyc_i & wb_stb_i & ~ack_r;
   wire       wr     = req & wb_we_i;
   wire       start_busy;
   wire       rec_busy;
   wire       adv_trig;
   wire       arm_trig;
   wire       ref_accept;

   assign wb_ack_o  = ack_r;
   assign wb_dat_o  = rdata_r;
   assign ref_trig_o = ref_out_r;
   assign adv_trig_o = adv_trig;
   assign arm_ref_o  = arm_trig;
   assign term_o     = term_r;
   assign term_oe_o  = term_oe_r;

   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer      b;
      begin
         for (b = 0; b < 4; b = b + 1) begin
            merge[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
         end
      end
   endfunction

   // addressed register with the enabled bytes of the write data laid over it
   wire [31:0] wr_word = merge(rdata_nxt, wb_dat_i, wb_sel_i);

   // two flip-flops before any logic sees a terminal
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_r <= {`ATR_NUM_LINES{1'b0}};
         sync2_r <= {`ATR_NUM_LINES{1'b0}};
      end else if (ce_i) begin
         sync1_r <= term_i;
         sync2_r <= sync1_r;
      end
   end

   // register writes; software trigger bits are one-cycle pulses
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         advance_trig_kind_r        <= `ATR_KIND_NONE;
         advance_edge_source_r      <= `ATR_TERM_NONE;
         advance_edge_pol_r         <= `ATR_POL_RISING;
         arm_ref_trig_kind_r        <= `ATR_KIND_NONE;
         arm_ref_edge_source_r      <= `ATR_TERM_NONE;
         arm_ref_edge_pol_r         <= `ATR_POL_RISING;
         export_r                   <= 16'h0000;
         record_to_record_holdoff_r <= 32'h0;
         start_to_record_holdoff_r  <= 32'h0;
         sw_adv_r                   <= 1'b0;
         sw_arm_r                   <= 1'b0;
         ack_r                      <= 1'b0;
         rdata_r                    <= 32'h0;
      end else if (ce_i) begin
         ack_r    <= req;
         sw_adv_r <= 1'b0;
         sw_arm_r <= 1'b0;
         if (req) begin
            rdata_r <= wb_we_i ? 32'h0 : rdata_nxt;
         end
         if (wr) begin
            case (wb_adr_i)
               `ATR_ADR_ADV_KIND: begin
                  advance_trig_kind_r <= wr_word[9:0];
               end
               `ATR_ADR_ADV_SRC: begin
                  advance_edge_source_r <= wr_word[3:0];
               end
               `ATR_ADR_ADV_POL: begin
                  advance_edge_pol_r <= wr_word[9:0];
               end
               `ATR_ADR_ARM_KIND: begin
                  arm_ref_trig_kind_r <= wr_word[9:0];
               end
               `ATR_ADR_ARM_SRC: begin
                  arm_ref_edge_source_r <= wr_word[3:0];
               end
               `ATR_ADR_ARM_POL: begin
                  arm_ref_edge_pol_r <= wr_word[9:0];
               end
               `ATR_ADR_EXPORT: begin
                  export_r <= wr_word[15:0];
               end
               `ATR_ADR_REC_HOLDOFF: begin
                  record_to_record_holdoff_r <= wr_word;
               end
               `ATR_ADR_START_HOLDOFF: begin
                  start_to_record_holdoff_r <= wr_word;
               end
               `ATR_ADR_SW_TRIG: begin
                  sw_adv_r <= wb_sel_i[0] & wb_dat_i[`ATR_SW_ADV_BIT]; // RULE6
                  sw_arm_r <= wb_sel_i[0] & wb_dat_i[`ATR_SW_ARM_BIT]; // RULE11
               end
               default: begin
               end
            endcase
         end
      end
   end

   // read mux; unmapped and write-only offsets read zero
   always @* begin
      rdata_nxt = 32'h0;
      case (wb_adr_i)
         `ATR_ADR_ADV_KIND:      rdata_nxt = {22'h0, advance_trig_kind_r};
         `ATR_ADR_ADV_SRC:       rdata_nxt = {28'h0, advance_edge_source_r};
         `ATR_ADR_ADV_POL:       rdata_nxt = {22'h0, advance_edge_pol_r};
         `ATR_ADR_ARM_KIND:      rdata_nxt = {22'h0, arm_ref_trig_kind_r};
         `ATR_ADR_ARM_SRC:       rdata_nxt = {28'h0, arm_ref_edge_source_r};
         `ATR_ADR_ARM_POL:       rdata_nxt = {22'h0, arm_ref_edge_pol_r};
         `ATR_ADR_EXPORT:        rdata_nxt = {16'h0, export_r};
         `ATR_ADR_REC_HOLDOFF:   rdata_nxt = record_to_record_holdoff_r;
         `ATR_ADR_START_HOLDOFF: rdata_nxt = start_to_record_holdoff_r;
         `ATR_ADR_STATUS: begin
            rdata_nxt[`ATR_ST_START_BUSY] = start_busy;
            rdata_nxt[`ATR_ST_REC_BUSY]   = rec_busy;
            rdata_nxt[`ATR_ST_STARTED]    = started_r;
         end
         default:                rdata_nxt = 32'h0;
      endcase
   end

   // advance trigger: kind, source, polarity
   atr_edge_trig u_adv (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .ce_i    (ce_i),
      .lines_i (sync2_r),
      .kind_i  (advance_trig_kind_r),   // RULE4 RULE5 RULE6
      .src_i   (advance_edge_source_r), // RULE7
      .pol_i   (advance_edge_pol_r),    // RULE15
      .sw_i    (sw_adv_r),
      .trig_o  (adv_trig)
   );

   // arm reference trigger: kind, source, polarity
   atr_edge_trig u_arm (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .ce_i    (ce_i),
      .lines_i (sync2_r),
      .kind_i  (arm_ref_trig_kind_r),   // RULE9 RULE10 RULE11
      .src_i   (arm_ref_edge_source_r), // RULE12
      .pol_i   (arm_ref_edge_pol_r),    // RULE15
      .sw_i    (sw_arm_r),
      .trig_o  (arm_trig)
   );

   // a start restarts its window and blocks a reference in the same cycle
   atr_holdoff u_start_hold (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .ce_i    (ce_i),
      .start_i (start_trig_i),              // RULE3
      .limit_i (start_to_record_holdoff_r), // RULE17
      .busy_o  (start_busy)
   );

   atr_holdoff u_rec_hold (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .ce_i    (ce_i),
      .start_i (ref_accept),                 // RULE2
      .limit_i (record_to_record_holdoff_r), // RULE17
      .busy_o  (rec_busy)
   );

   assign ref_accept = ref_trig_i & ~start_trig_i & ~start_busy & ~rec_busy; // RULE2 RULE3

   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_out_r <= 1'b0;
         started_r <= 1'b0;
      end else if (ce_i) begin
         ref_out_r <= ref_accept;
         if (start_trig_i) begin
            started_r <= 1'b1;
         end
      end
   end

   // per terminal: enable while any export selects it, drive the one-cycle pulses
   genvar i;
   generate
      for (i = 0; i < `ATR_NUM_LINES; i = i + 1) begin : g_term
         localparam [3:0] CODE = i + 1;
         wire hit_ref  = (ref_trig_export_select == CODE);      // RULE1
         wire hit_adv  = (advance_export_select == CODE);       // RULE8
         wire hit_rst  = (ready_start_export_select == CODE);   // RULE13
         wire hit_radv = (ready_advance_export_select == CODE); // RULE14
         always @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               term_r[i]    <= 1'b0;
               term_oe_r[i] <= 1'b0;
            end else if (ce_i) begin
               term_oe_r[i] <= hit_ref | hit_adv | hit_rst | hit_radv; // RULE16
               term_r[i]    <= (hit_ref & ref_accept) | (hit_adv & adv_trig)
                               | (hit_rst & ready_start_i) | (hit_radv & ready_adv_i); // RULE16
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* File: tb/atr_props.sv */
`timescale 1ns/1ps
`default_nettype none
module atr_props (
   input wire logic        clock_i,      // system clock
   input wire logic        nrst_i,       // reset, active low
   input wire logic        ce_i,         // clock enable
   input wire logic        wb_cyc_i,     // bus cycle
   input wire logic        wb_stb_i,     // bus strobe
   input wire logic        wb_we_i,      // bus write
   input wire logic        wb_ack_o,     // bus acknowledge
   input wire logic [31:0] wb_dat_o,     // bus read data
   input wire logic        start_trig_i, // start accepted
   input wire logic        ref_trig_i,   // reference candidate
   input wire logic        ref_trig_o,   // reference recognised
   input wire logic        adv_trig_o,   // advance trigger
   input wire logic        arm_ref_o,    // arm reference trigger
   input wire logic [10:0] term_o,       // pin drive
   input wire logic [10:0] term_oe_o     // pin enables
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   ack_latency_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not given one cycle after request");
   ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   write_zero_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
      else $error("read data not zero on write");
   ref_cause_a: assert property (ref_trig_o |-> $past(ref_trig_i && !start_trig_i))
      else $error("reference out without allowed candidate");
   adv_pulse_a: assert property (adv_trig_o |=> !adv_trig_o)
      else $error("advance pulse too long");
   arm_pulse_a: assert property (arm_ref_o |=> !arm_ref_o)
      else $error("arm pulse too long");
   oe_guard_a: assert property ((term_o & ~term_oe_o) == 11'h0)
      else $error("pin driven high without enable");
   freeze_hold_a: assert property (!ce_i |=> $stable(term_o) && $stable(term_oe_o) && $stable(wb_ack_o))
      else $error("outputs moved while clock enable low");
endmodule
`default_nettype wire

/* File: tb/atr_chassis.sv */
`timescale 1ns/1ps
`default_nettype none
// other instruments drive every line that the router leaves released
module atr_chassis (
   input  wire logic [10:0] lvl_i,    // levels of other instruments
   input  wire logic [10:0] dut_o_i,  // router drive
   input  wire logic [10:0] dut_oe_i, // router enables
   output logic      [10:0] line_o    // resolved line levels
);
   assign line_o = (dut_oe_i & dut_o_i) | (~dut_oe_i & lvl_i);
endmodule
`default_nettype wire

/* File: tb/atr_router_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "atr_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module atr_router_tb;
   logic        clock_i = 0;
   logic        nrst_i = 0;
   logic        ce_i = 1;
   logic        cyc = 0, stb = 0, we = 0, start = 0, ref_i = 0, rs = 0, ra = 0;
   logic [7:0]  adr = 0;
   logic [3:0]  sel = 0;
   logic [31:0] dat = 0, q, d1, d2, seed = 32'hbac836aa;
   logic [10:0] lvl = 0, lines, seen;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, ref_trig_o, adv_trig_o, arm_ref_o;
   wire  [10:0] term_o, term_oe_o;
   logic [7:0]  al [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c};
   int          miscompares = 0, samples_checked = 0, cnt [2] = '{0, 0}, c, n, m, s;
   always #2.5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      if (adv_trig_o === 1'b1) cnt[0]++;
      if (arm_ref_o === 1'b1) cnt[1]++;
   end
   atr_router i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .start_trig_i(start), .ref_trig_i(ref_i), .ready_start_i(rs), .ready_adv_i(ra), .ref_trig_o(ref_trig_o),
      .adv_trig_o(adv_trig_o), .arm_ref_o(arm_ref_o), .term_i(lines), .term_o(term_o), .term_oe_o(term_oe_o));
   atr_chassis i_chassis (.lvl_i(lvl), .dut_o_i(term_o), .dut_oe_i(term_oe_o), .line_o(lines));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] rst_val(input logic [7:0] a);
      if (a == 8'h00 || a == 8'h0c) return {22'h0, `ATR_KIND_NONE};
      if (a == 8'h08 || a == 8'h14) return {22'h0, `ATR_POL_RISING};
      return 32'h0;
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
      for (int i = 0; i < 4; i++) if (b[i]) o[8*i +: 8] = d[8*i +: 8];
      return o;
   endfunction
   function automatic logic [10:0] emask(input int code);
      return (code == 0) ? 11'h0 : 11'h1 << (code - 1);
   endfunction
   task automatic final_report();
      if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge clock_i);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      int k;
      @(posedge clock_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= b;
      k = 0;
      do begin @(posedge clock_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
      q = wb_dat_o;
      cyc <= 0;
      stb <= 0;
      if (k >= 20) begin miscompares++; final_report(); end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hf);
   endtask
   task automatic tog(input int b);
      @(posedge clock_i);
      lvl[b] <= ~lvl[b];
      idle(6);
   endtask
   task automatic wref();
      c = 0;
      do begin @(posedge clock_i); c++; end while (ref_trig_o !== 1'b1 && c < 40);
      if (c >= 40) begin miscompares++; final_report(); end
   endtask
   initial begin
      idle(3);
      nrst_i <= 1;
      foreach (al[i]) begin wb(1'b0, al[i], 32'h0, 4'hf); `CHK("reset_value", rst_val(al[i]), q) end
      w(8'h2c, rnd());
      wb(1'b0, 8'h2c, 32'h0, 4'hf);
      `CHK("unmapped", 32'h0, q)
      repeat (4) begin
         d1 = rnd();
         d2 = rnd();
         s = rnd();
         w(`ATR_ADR_REC_HOLDOFF, d1);
         wb(1'b1, `ATR_ADR_REC_HOLDOFF, d2, s[3:0]);
         wb(1'b0, `ATR_ADR_REC_HOLDOFF, 32'h0, 4'hf);
         `CHK("byte_select", merge(d1, d2, s[3:0]), q)
      end
      w(`ATR_ADR_REC_HOLDOFF, 32'h0);
      // kinds still none: neither edges nor software commands may fire
      m = cnt[0] + cnt[1];
      w(`ATR_ADR_ADV_SRC, 32'h1);
      w(`ATR_ADR_ARM_SRC, 32'h1);
      tog(0);
      tog(0);
      w(`ATR_ADR_SW_TRIG, 32'h3);
      idle(6);
      `CHK("kind_none", 1'b1, cnt[0] + cnt[1] == m)
      for (int t = 0; t < 2; t++) begin
         w(8'h0c * t, `ATR_KIND_SOFTWARE);
         m = cnt[t];
         tog(0);
         `CHK("sw_ignores_edge", 1'b1, cnt[t] == m)
         w(`ATR_ADR_SW_TRIG, 32'h1 << t);
         @(posedge clock_i);
         `CHK("sw_pulse", 1'b1, t ? arm_ref_o : adv_trig_o)
      end
      for (int t = 0; t < 2; t++) for (int sr = 1; sr < 12; sr++) for (int p = 0; p < 2; p++) begin
         @(posedge clock_i);
         lvl <= p ? 11'h7ff : 11'h0;
         idle(6);
         w(8'h0c * t, `ATR_KIND_DIG_EDGE);
         w(8'h0c * t + 8'h04, sr);
         w(8'h0c * t + 8'h08, p ? `ATR_POL_FALLING : `ATR_POL_RISING);
         idle(6);
         m = cnt[t];
         tog(sr % 11);
         `CHK("other_source", 1'b1, cnt[t] == m)
         tog(sr - 1);
         `CHK("active_edge", 1'b1, cnt[t] == m + 1)
         tog(sr - 1);
         `CHK("inactive_edge", 1'b1, cnt[t] == m + 1)
      end
      w(`ATR_ADR_ADV_KIND, `ATR_KIND_SOFTWARE);
      w(`ATR_ADR_ARM_KIND, `ATR_KIND_NONE);
      for (int f = 0; f < 4; f++) for (int code = 0; code < 12; code++) begin
         w(`ATR_ADR_EXPORT, code << (4 * f));
         idle(2);
         `CHK("export_enable", emask(code), term_oe_o)
         if (f == 1) w(`ATR_ADR_SW_TRIG, 32'h1);
         else begin
            @(posedge clock_i);
            ref_i <= (f == 0);
            rs <= (f == 2);
            ra <= (f == 3);
            @(posedge clock_i);
            {ref_i, rs, ra} <= 3'h0;
         end
         seen = 0;
         repeat (5) begin @(posedge clock_i); seen |= term_o; end
         `CHK("export_pulse", emask(code), seen)
      end
      w(`ATR_ADR_EXPORT, 32'h0);
      repeat (4) begin
         d1 = rnd() % 61;
         d2 = rnd() % 61;
         w(`ATR_ADR_START_HOLDOFF, d1);
         w(`ATR_ADR_REC_HOLDOFF, d2);
         n = (d1 + 4) / 5;
         m = (d2 + 4) / 5;
         @(posedge clock_i);
         start <= 1;
         @(posedge clock_i);
         start <= 0;
         ref_i <= 1;
         wref();
         `CHK("start_holdoff", 1'b1, c >= n + 2 && c <= n + 3)
         wref();
         `CHK("record_holdoff", 1'b1, c >= m + 1 && c <= m + 2)
         @(posedge clock_i);
         ref_i <= 0;
         idle(30);
      end
      @(posedge clock_i);
      ce_i <= 0;
      idle(3);
      ce_i <= 1;
      idle(3);
      final_report();
   end
endmodule
bind atr_router atr_props i_props (.clock_i, .nrst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
   .wb_dat_o, .start_trig_i, .ref_trig_i, .ref_trig_o, .adv_trig_o, .arm_ref_o, .term_o, .term_oe_o);
`default_nettype wire
